// ===== design/edge_event_pkg.sv
// shared constants for the edge and event line controller
package edge_event_pkg;

  localparam int          NUM_LINES   = 24;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          SYNC_STAGES = 3;

  localparam logic [7:0]  OFF_MASK    = 8'h00;
  localparam logic [7:0]  OFF_MODE    = 8'h04;
  localparam logic [7:0]  OFF_RISE    = 8'h08;
  localparam logic [7:0]  OFF_FALL    = 8'h0C;
  localparam logic [7:0]  OFF_PEND    = 8'h10;
  localparam logic [7:0]  OFF_LEVEL   = 8'h14;

  localparam logic [23:0] RST_MASK    = 24'h00_0000;
  localparam logic [23:0] RST_MODE    = 24'h00_0000;
  localparam logic [23:0] RST_RISE    = 24'h00_0000;
  localparam logic [23:0] RST_FALL    = 24'h00_0000;
  localparam logic [23:0] RST_PEND    = 24'h00_0000;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

endpackage

// ===== design/edge_event_unit.sv
// edge and event line controller with wishbone register access
//
// How it works
// - twenty-four lines, each with edge detection
// - per line choice of interrupt or event
// - per line rising, falling or both edges
// - per line mask blocks forwarding of requests
// - pending bit records interrupt until cleared
// - writing one clears pending, zero keeps it
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/10ps
module edge_event_unit #(
  parameter int NUM_LINES = edge_event_pkg::NUM_LINES
) (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic [NUM_LINES-1:0]              line_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [edge_event_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [edge_event_pkg::DATA_W-1:0] wb_dat_i,
  input  wire logic [3:0]                        wb_sel_i,
  output logic      [edge_event_pkg::DATA_W-1:0] wb_dat_o,
  output logic                                   wb_ack_o,
  output logic                                   irq_o,
  output logic      [NUM_LINES-1:0]              event_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [NUM_LINES-1:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return m[NUM_LINES-1:0];
  endfunction

  function automatic logic [NUM_LINES-1:0] merge(input logic [NUM_LINES-1:0] old,
                                                 input logic [31:0]          wdat,
                                                 input logic [3:0]           sel);
    logic [NUM_LINES-1:0] m;
    m = lane_mask(sel);
    return (old & ~m) | (wdat[NUM_LINES-1:0] & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus request qualification

  logic                 req;
  logic                 wr;
  logic [NUM_LINES-1:0] level;
  logic [NUM_LINES-1:0] level_q_reg;
  logic [NUM_LINES-1:0] mask_reg;
  logic [NUM_LINES-1:0] mode_reg;
  logic [NUM_LINES-1:0] rise_reg;
  logic [NUM_LINES-1:0] fall_reg;
  logic [NUM_LINES-1:0] pend_reg;
  logic [NUM_LINES-1:0] pend_next;
  logic [NUM_LINES-1:0] edge_hit;
  logic [NUM_LINES-1:0] clr_bits;
  logic [31:0]          rd_next;

  // one access per handshake: the cycle in which ack is high is never taken again
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // input lines and edge detection

  line_sync #(
    .WIDTH (NUM_LINES)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (line_i),
    .level_o   (level)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_q_reg <= '0;
    else
      level_q_reg <= level;
  end

  // both enables set gives detection in both directions
  assign edge_hit = (rise_reg & level & ~level_q_reg)
                  | (fall_reg & ~level & level_q_reg);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mask_reg <= edge_event_pkg::RST_MASK;
    else if (wr && wb_adr_i == edge_event_pkg::OFF_MASK)
      mask_reg <= merge(mask_reg, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_reg <= edge_event_pkg::RST_MODE;
    else if (wr && wb_adr_i == edge_event_pkg::OFF_MODE)
      mode_reg <= merge(mode_reg, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rise_reg <= edge_event_pkg::RST_RISE;
    else if (wr && wb_adr_i == edge_event_pkg::OFF_RISE)
      rise_reg <= merge(rise_reg, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fall_reg <= edge_event_pkg::RST_FALL;
    else if (wr && wb_adr_i == edge_event_pkg::OFF_FALL)
      fall_reg <= merge(fall_reg, wb_dat_i, wb_sel_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending bits and interrupt output

  // the mask gates the interrupt and event outputs but not pending, so software can still poll masked lines
  assign clr_bits  = (wr && wb_adr_i == edge_event_pkg::OFF_PEND)
                   ? (wb_dat_i[NUM_LINES-1:0] & lane_mask(wb_sel_i))
                   : '0;
  // a new edge in the clearing cycle wins over the clear
  assign pend_next = (pend_reg & ~clr_bits) | (edge_hit & ~mode_reg);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pend_reg <= edge_event_pkg::RST_PEND;
    else
      pend_reg <= pend_next;
  end

  // taken from the next value so the output lines up with the pending flop
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(pend_next & mask_reg & ~mode_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // event pulses

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      event_o <= '0;
    else
      event_o <= edge_hit & mode_reg & mask_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone read data and ack

  always_comb
  begin
    rd_next = edge_event_pkg::RD_ZERO;
    case (wb_adr_i)
      edge_event_pkg::OFF_MASK:  rd_next[NUM_LINES-1:0] = mask_reg;
      edge_event_pkg::OFF_MODE:  rd_next[NUM_LINES-1:0] = mode_reg;
      edge_event_pkg::OFF_RISE:  rd_next[NUM_LINES-1:0] = rise_reg;
      edge_event_pkg::OFF_FALL:  rd_next[NUM_LINES-1:0] = fall_reg;
      edge_event_pkg::OFF_PEND:  rd_next[NUM_LINES-1:0] = pend_reg;
      edge_event_pkg::OFF_LEVEL: rd_next[NUM_LINES-1:0] = level;
      default:                   rd_next = edge_event_pkg::RD_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wb_dat_o <= edge_event_pkg::RD_ZERO;
    else if (req && !wb_we_i)
      wb_dat_o <= rd_next;
  end

endmodule

// ===== design/line_sync.sv
// three-stage input synchroniser with agreement filter, one per line
`timescale 1ns/10ps
module line_sync #(
  parameter int WIDTH = 24
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  logic [WIDTH-1:0] agree;

  // a line only moves once the last two stages agree, so a single-cycle glitch is ignored
  assign agree = ~(stage2_reg ^ stage3_reg);

  // one process owns the whole output vector, so no bit has two writers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_o <= '0;
    else
      level_o <= (stage3_reg & agree) | (level_o & ~agree);
  end

endmodule

// ===== sim/edge_event_props.sv
// port assertions for the edge and event line controller
`timescale 1ns/10ps
module edge_event_props #(
  parameter int NUM_LINES = 24
) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire logic [NUM_LINES-1:0] line_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 irq_o,
  input wire logic [NUM_LINES-1:0] event_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_top_zero; wb_dat_o[31:24] == 8'h00; endproperty
  a_top_zero: assert property (p_top_zero) else $error("top byte set");
  property p_unmapped; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h20
    |=> wb_dat_o == edge_event_pkg::RD_ZERO; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_event_one; (event_o & $past(event_o)) == '0; endproperty
  a_event_one: assert property (p_event_one) else $error("event wide");
  // irq only drops through a register write: clear, mask or mode
  property p_irq_fall; $fell(irq_o) |-> (wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_mask_off; wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF
    && wb_adr_i == edge_event_pkg::OFF_MASK && wb_dat_i[23:0] == 24'h00_0000 |=> ##1 !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq");
  c_irq: cover property ($rose(irq_o));
  c_event: cover property (event_o != '0);
  c_clear: cover property ($fell(irq_o));
endmodule
bind edge_event_unit edge_event_props #(.NUM_LINES(NUM_LINES)) u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .line_i(line_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .event_o(event_o));

// ===== sim/line_source.sv
// peripheral line sources and event pulse counter at the far side
`timescale 1ns/10ps
module line_source (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [23:0] line_req_i,
  input  wire logic [23:0] event_i,
  output logic      [23:0] line_o,
  output logic      [7:0]  ev_count_o
);
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      line_o <= 24'h00_0000;
    else
      line_o <= line_req_i;
  end
  // pulses are one cycle wide, so set bits per edge count detected edges
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ev_count_o <= 8'h00;
    else
      ev_count_o <= ev_count_o + 8'($countones(event_i));
  end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the edge and event line controller
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] dat;
  logic [3:0]  sel;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic [23:0] ev;
  logic [23:0] line;
  logic [23:0] line_req;
  logic [7:0]  ev_cnt;
  logic [31:0] q;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  edge_event_unit u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .line_i(line),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .event_o(ev));
  line_source u_src (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .line_req_i(line_req),
    .event_i(ev), .line_o(line), .ev_count_o(ev_cnt));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task print_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // single classic cycle; waits on ack with no assumed latency
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    @(posedge sys_clk_i);
    while (ack !== 1'b1) @(posedge sys_clk_i);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task settle(input logic [23:0] v);
    line_req <= v;
    repeat (10) @(posedge sys_clk_i);
  endtask
  task t_reset();
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0000_0000, "reset value");
    xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, "unmapped");
  endtask
  // line0 irq rise; line1 irq rise masked; line2 event both; line3 event fall; line4 masked
  task t_config();
    xfer(1'b1, edge_event_pkg::OFF_MASK, 32'h0000_000D);
    xfer(1'b1, edge_event_pkg::OFF_MODE, 32'h0000_001C);
    xfer(1'b1, edge_event_pkg::OFF_RISE, 32'h0000_0017);
    xfer(1'b1, edge_event_pkg::OFF_FALL, 32'h0000_000C);
    rd(edge_event_pkg::OFF_MODE, 32'h0000_001C, "mode");
  endtask
  task t_edges();
    settle(24'h00_001F);
    rd(edge_event_pkg::OFF_LEVEL, 32'h0000_001F, "level");
    rd(edge_event_pkg::OFF_PEND, 32'h0000_0003, "pending");
    chk("irq", 32'h0000_0001, {31'h0, irq});
    chk("events", 32'h0000_0001, {24'h00_0000, ev_cnt});
    settle(24'h00_0000);
    chk("events", 32'h0000_0003, {24'h00_0000, ev_cnt});
    rd(edge_event_pkg::OFF_PEND, 32'h0000_0003, "pending");
  endtask
  task t_clear();
    xfer(1'b1, edge_event_pkg::OFF_PEND, 32'h0000_0000);
    rd(edge_event_pkg::OFF_PEND, 32'h0000_0003, "pending");
    xfer(1'b1, edge_event_pkg::OFF_PEND, 32'h0000_0001);
    rd(edge_event_pkg::OFF_PEND, 32'h0000_0002, "pending");
    chk("irq", 32'h0000_0000, {31'h0, irq});
    xfer(1'b1, edge_event_pkg::OFF_MASK, 32'h0000_000F);
    @(posedge sys_clk_i);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    xfer(1'b1, edge_event_pkg::OFF_MASK, 32'h0000_0000);
    xfer(1'b1, edge_event_pkg::OFF_PEND, 32'h0000_0002);
    rd(edge_event_pkg::OFF_PEND, 32'h0000_0000, "pending");
    chk("irq", 32'h0000_0000, {31'h0, irq});
  endtask
  initial
  begin
    rst_n_i = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    dat = 32'h0000_0000; sel = 4'h0; line_req = 24'h00_0000;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_config();
    t_edges();
    t_clear();
    print_verdict();
  end
endmodule
